// ===== logic/iretc_pkg.sv
// Purpose: constants for the interrupt enable and tick calibration block
// Assumes: AXI4-Lite, 32-bit data, 125 MHz core clock
// Notes: register offsets are byte addresses
package iretc_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] IRETC_OFF_CALIB = 8'h00;
	localparam logic [7:0] IRETC_OFF_ENA_LOW = 8'h04;
	localparam logic [7:0] IRETC_OFF_ENA_HIGH = 8'h08;
	localparam logic [7:0] IRETC_OFF_STATUS = 8'h0C;
	// ----------------------------------------
	// calibration word layout
	// ----------------------------------------
	localparam int IRETC_BIT_REF_ABSENT = 31;
	localparam int IRETC_BIT_INEXACT = 30;
	localparam logic [23:0] IRETC_TEN_MS_RELOAD = 24'h0009C4;
	localparam int IRETC_RELOAD_WIDTH = 24;
	// ----------------------------------------
	// enables and tick divider
	// ----------------------------------------
	localparam int IRETC_NUM_IRQ = 50;
	localparam int IRETC_HIGH_BITS = 18;
	localparam int IRETC_OSC_DIVIDE = 32;
	localparam int IRETC_DIV_WIDTH = 5;
	localparam logic [1:0] IRETC_RESP_OKAY = 2'b00;
	localparam logic [1:0] IRETC_RESP_SLVERR = 2'b10;
	localparam logic [31:0] IRETC_ZERO_WORD = 32'h00000000;
endpackage : iretc_pkg

// ===== logic/iretc_tick_divider.sv
// Purpose: divide the oscillator input by a fixed ratio into a one-cycle tick enable
// Assumes: osc_input_pin is a level synchronous to aclk
// Notes: counts rising edges of the oscillator input
`timescale 1ns/100ps
module iretc_tick_divider #(
	parameter int DIVIDE = iretc_pkg::IRETC_OSC_DIVIDE,
	parameter int WIDTH = iretc_pkg::IRETC_DIV_WIDTH
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic osc_input_pin,
	output logic tick_enable
);
	import iretc_pkg::*;
	typedef struct packed {
		logic osc_prev;
		logic [WIDTH-1:0] count;
		logic tick;
	} iretc_div_state_type;
	iretc_div_state_type state;
	iretc_div_state_type next_state;
	logic osc_rise;
	// ----------------------------------------
	// divider
	// ----------------------------------------
	// one pulse per DIVIDE oscillator rising edges
	always_comb begin
		next_state = state;
		next_state.osc_prev = osc_input_pin;
		next_state.tick = 1'b0;
		osc_rise = osc_input_pin & ~state.osc_prev;
		if (osc_rise) begin
			if (state.count == WIDTH'(DIVIDE - 1)) begin
				next_state.count = '0;
				next_state.tick = 1'b1;
			end else begin
				next_state.count = state.count + WIDTH'(1);
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end
	assign tick_enable = state.tick;
endmodule : iretc_tick_divider

// ===== logic/iretc_enable_bank.sv
// Purpose: write-one-to-set interrupt enable bits
// Assumes: set strobe is one cycle wide
// Notes: no clear path here; clear-enable lives elsewhere
`timescale 1ns/100ps
module iretc_enable_bank #(
	parameter int WIDTH = iretc_pkg::IRETC_NUM_IRQ
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic set_valid,
	input wire logic [WIDTH-1:0] set_mask,
	output logic [WIDTH-1:0] irq_enable
);
	import iretc_pkg::*;
	typedef struct packed {
		logic [WIDTH-1:0] ena;
	} iretc_bank_state_type;
	iretc_bank_state_type state;
	iretc_bank_state_type next_state;
	// ----------------------------------------
	// enable bits
	// ----------------------------------------
	// ones set, zeros leave the bit alone
	always_comb begin
		next_state = state;
		if (set_valid) begin
			next_state.ena = state.ena | set_mask;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end
	assign irq_enable = state.ena;
endmodule : iretc_enable_bank

// ===== logic/iretc_top.sv
// Purpose: interrupt set-enable registers and tick calibration word on AXI4-Lite
// Assumes: one clock, synchronous active-low reset, one access of each kind at a time
// Notes: answers one cycle after both halves of a request are held
// Function
// - Calibration bit 31 reads 0 with a reference clock present and 1 without.
// - Calibration bit 30 reads 0 when the constant gives exactly 10 ms, else 1.
// - Calibration bits 23 to 0 read the reload constant 0x9C4 for a 10 ms tick.
// - The tick counter is clocked from the oscillator input divided by 32.
// - The constant gives 10 ms when the oscillator input runs at 8 MHz.
// - Bits 31 to 0 of the low set-enable register map to interrupt lines 31 to 0.
// - Writing 1 to a set-enable bit enables its line, writing 0 changes nothing.
// - Reading a set-enable register returns the current enable of each line.
`timescale 1ns/100ps
module iretc_top #(
	parameter int NUM_IRQ = iretc_pkg::IRETC_NUM_IRQ,
	parameter logic REF_ABSENT = 1'b0,
	parameter logic [23:0] RELOAD = iretc_pkg::IRETC_TEN_MS_RELOAD
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic osc_input_pin,
	output logic [iretc_pkg::IRETC_NUM_IRQ-1:0] irq_enable_set,
	output logic tick_enable
);
	import iretc_pkg::*;
	localparam int OSC_HZ = 8000000;
	localparam int TICK_MS = 10;
	// reload that yields the tick period at the nominal oscillator rate
	localparam int EXACT_RELOAD = OSC_HZ / IRETC_OSC_DIVIDE / 1000 * TICK_MS;

	typedef struct packed {
		logic aw_held;
		logic [7:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic inexact;
	} iretc_state_type;
	iretc_state_type state;
	iretc_state_type next_state;
	logic do_write;
	logic set_low;
	logic set_high;
	logic [NUM_IRQ-1:0] set_mask;
	logic [31:0] wmask;
	logic [31:0] read_word;
	logic read_ok;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// byte strobes widened to a bit mask
	function automatic logic [31:0] iretc_strb_mask(input logic [3:0] strb);
		logic [31:0] m;
		m = '0;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{strb[i]}};
		end
		return m;
	endfunction : iretc_strb_mask

	// address decode shared by read and write
	function automatic logic iretc_hit(input logic [7:0] addr, input logic [7:0] off);
		return addr[7:2] == off[7:2];
	endfunction : iretc_hit

	// ----------------------------------------
	// sub-blocks
	// ----------------------------------------
	iretc_enable_bank #(.WIDTH(NUM_IRQ)) u_bank (
		.aclk(aclk),
		.aresetn(aresetn),
		.set_valid(set_low | set_high),
		.set_mask(set_mask),
		.irq_enable(irq_enable_set)
	);

	iretc_tick_divider u_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.osc_input_pin(osc_input_pin),
		.tick_enable(tick_enable)
	);

	// ----------------------------------------
	// write decode
	// ----------------------------------------
	// masked write data routed to the matching half of the enables
	always_comb begin
		wmask = state.w_data & iretc_strb_mask(state.w_strb);
		do_write = state.aw_held & state.w_held & ~state.bvalid;
		set_low = do_write & iretc_hit(state.aw_addr, IRETC_OFF_ENA_LOW);
		set_high = do_write & iretc_hit(state.aw_addr, IRETC_OFF_ENA_HIGH);
		set_mask = '0;
		if (set_low) begin
			set_mask[31:0] = wmask;
		end
		if (set_high) begin
			set_mask[NUM_IRQ-1:32] = wmask[IRETC_HIGH_BITS-1:0];
		end
	end

	// ----------------------------------------
	// read decode
	// ----------------------------------------
	always_comb begin
		read_word = IRETC_ZERO_WORD;
		read_ok = 1'b1;
		if (iretc_hit(s_axi_araddr, IRETC_OFF_CALIB)) begin
			read_word[IRETC_BIT_REF_ABSENT] = REF_ABSENT;
			read_word[IRETC_BIT_INEXACT] = state.inexact;
			read_word[IRETC_RELOAD_WIDTH-1:0] = RELOAD;
		end else if (iretc_hit(s_axi_araddr, IRETC_OFF_ENA_LOW)) begin
			read_word = irq_enable_set[31:0];
		end else if (iretc_hit(s_axi_araddr, IRETC_OFF_ENA_HIGH)) begin
			read_word[IRETC_HIGH_BITS-1:0] = irq_enable_set[NUM_IRQ-1:32];
		end else if (iretc_hit(s_axi_araddr, IRETC_OFF_STATUS)) begin
			read_word[0] = tick_enable;
		end else begin
			read_ok = 1'b0;
		end
	end

	// ----------------------------------------
	// bus channel state
	// ----------------------------------------
	// address and data are caught separately so either may come first
	always_comb begin
		next_state = state;
		// flag follows the reload parameter against the nominal 10 ms value
		next_state.inexact = (RELOAD != 24'(EXACT_RELOAD));
		if (s_axi_awvalid && s_axi_awready) begin
			next_state.aw_held = 1'b1;
			next_state.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_state.w_held = 1'b1;
			next_state.w_data = s_axi_wdata;
			next_state.w_strb = s_axi_wstrb;
		end
		if (do_write) begin
			next_state.aw_held = 1'b0;
			next_state.w_held = 1'b0;
			next_state.bvalid = 1'b1;
			// only the two enable registers take writes
			next_state.bresp = (set_low | set_high) ? IRETC_RESP_OKAY : IRETC_RESP_SLVERR;
		end
		if (state.bvalid && s_axi_bready) begin
			next_state.bvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_state.rvalid = 1'b1;
			next_state.rdata = read_word;
			next_state.rresp = read_ok ? IRETC_RESP_OKAY : IRETC_RESP_SLVERR;
		end else if (state.rvalid && s_axi_rready) begin
			next_state.rvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// ready is held low while a half is waiting for its partner
	assign s_axi_awready = ~state.aw_held & ~state.bvalid;
	assign s_axi_wready = ~state.w_held & ~state.bvalid;
	assign s_axi_arready = ~state.rvalid;
	assign s_axi_bvalid = state.bvalid;
	assign s_axi_bresp = state.bresp;
	assign s_axi_rvalid = state.rvalid;
	assign s_axi_rdata = state.rdata;
	assign s_axi_rresp = state.rresp;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_calib_ref_flag: assert property (
		s_axi_arvalid && s_axi_arready && iretc_hit(s_axi_araddr, IRETC_OFF_CALIB)
		|=> s_axi_rdata[31] == REF_ABSENT) else $error("reference flag wrong");
	a_calib_calibration_inexact_flag: assert property (
		s_axi_arvalid && s_axi_arready && iretc_hit(s_axi_araddr, IRETC_OFF_CALIB)
		|=> s_axi_rdata[30] == (RELOAD != 24'(EXACT_RELOAD))) else $error("accuracy flag wrong");
	a_calib_reload_value: assert property (
		s_axi_arvalid && s_axi_arready && iretc_hit(s_axi_araddr, IRETC_OFF_CALIB)
		|=> s_axi_rdata[23:0] == RELOAD && s_axi_rdata[29:24] == 6'h00) else $error("reload wrong");
	a_tick_spacing: assert property (
		tick_enable |=> !tick_enable [*2]) else $error("tick too close");
	a_nominal_period: assert property (
		RELOAD != 24'(EXACT_RELOAD) || !state.inexact ##0 EXACT_RELOAD == 2500) else $error("nominal reload off");
	a_low_set_map: assert property (
		set_low |=> (irq_enable_set[31:0] & $past(wmask)) == $past(wmask)) else $error("low enable not set");
	a_enable_sticky: assert property (
		(irq_enable_set & $past(irq_enable_set)) == $past(irq_enable_set)) else $error("enable dropped");
	a_low_read_back: assert property (
		s_axi_arvalid && s_axi_arready && iretc_hit(s_axi_araddr, IRETC_OFF_ENA_LOW)
		|=> s_axi_rdata == $past(irq_enable_set[31:0])) else $error("low readback wrong");
	a_high_read_back: assert property (
		s_axi_arvalid && s_axi_arready && iretc_hit(s_axi_araddr, IRETC_OFF_ENA_HIGH)
		|=> s_axi_rdata[31:18] == 14'h0000 && s_axi_rdata[17:0] == $past(irq_enable_set[49:32]))
		else $error("high readback wrong");
	a_write_answer: assert property (
		do_write |=> s_axi_bvalid) else $error("write not answered");

	// ----------------------------------------
	// checks: bus handshakes
	// ----------------------------------------
	// an answer stands untouched until the master takes it
	a_bresp_held: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped early");
	a_rdata_held: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read answer dropped early");
	// each read is answered on the cycle after it is taken
	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read not answered");
	// no new write may be taken while its answer is still pending
	a_write_refused: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken during answer");
	// every word above the status register is refused, reads with zero data
	a_unmapped_read: assert property (
		s_axi_arvalid && s_axi_arready && s_axi_araddr > (IRETC_OFF_STATUS | 8'h03)
		|=> s_axi_rresp == IRETC_RESP_SLVERR && s_axi_rdata == IRETC_ZERO_WORD)
		else $error("unmapped read not refused");
	// writes above the status register are refused as well
	a_unmapped_write: assert property (
		do_write && state.aw_addr > (IRETC_OFF_STATUS | 8'h03)
		|=> s_axi_bresp == IRETC_RESP_SLVERR) else $error("unmapped write not refused");
	// the calibration word is read-only, so a write there must touch no line
	a_calib_write_ignored: assert property (
		do_write && iretc_hit(state.aw_addr, IRETC_OFF_CALIB)
		|=> $stable(irq_enable_set) && s_axi_bresp == IRETC_RESP_SLVERR) else $error("calibration write took effect");

	// ----------------------------------------
	// checks: enables, reset and tick
	// ----------------------------------------
	// the high register reaches lines 49 to 32 only through its low bits
	a_high_set_map: assert property (
		set_high |=> (irq_enable_set[NUM_IRQ-1:32] & $past(wmask[IRETC_HIGH_BITS-1:0]))
		== $past(wmask[IRETC_HIGH_BITS-1:0])) else $error("high enable not set");
	// each register only reaches its own half of the lines
	a_low_write_only: assert property (
		set_low |=> $stable(irq_enable_set[NUM_IRQ-1:32])) else $error("low write touched high lines");
	a_high_write_only: assert property (
		set_high |=> $stable(irq_enable_set[31:0])) else $error("high write touched low lines");
	// a write that sets nothing leaves every line as it was
	a_zero_write_idle: assert property (
		do_write && wmask == IRETC_ZERO_WORD |=> $stable(irq_enable_set)) else $error("zero write changed lines");
	// reset is checked on its own, since the default disable hides it
	a_reset_clear: assert property (
		@(posedge aclk) disable iff (1'b0)
		!aresetn |=> irq_enable_set == '0 && !s_axi_bvalid && !s_axi_rvalid && !tick_enable)
		else $error("reset left state behind");
	// a tick follows one cycle after the oscillator was seen low then high
	a_tick_on_edge: assert property (
		tick_enable |-> $past(osc_input_pin) && !$past(osc_input_pin, 2)) else $error("tick without oscillator edge");
	// status shows the tick as it stood when the read was taken
	a_status_read: assert property (
		s_axi_arvalid && s_axi_arready && iretc_hit(s_axi_araddr, IRETC_OFF_STATUS)
		|=> s_axi_rdata == {31'h00000000, $past(tick_enable)} && s_axi_rresp == IRETC_RESP_OKAY)
		else $error("status read wrong");

	// main scenarios worth seeing at least once

	c_write_low: cover property (set_low ##1 s_axi_bvalid);
	c_write_high: cover property (set_high);
	c_read_calib: cover property (s_axi_arvalid && s_axi_arready && iretc_hit(s_axi_araddr, IRETC_OFF_CALIB));
	c_tick: cover property (tick_enable);
	c_read_status: cover property (s_axi_arvalid && s_axi_arready && iretc_hit(s_axi_araddr, IRETC_OFF_STATUS));
endmodule : iretc_top

// ===== dv/iretc_top_test.sv
// Purpose: self-checking bench for the interrupt enable and tick calibration block
// Assumes: AXI4-Lite master driven here, answers waited for under a bound
// Notes: oscillator toggles every two clocks so the divider can see each edge
`timescale 1ns/100ps
module iretc_top_test;
	import iretc_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0] wstrb = 4'h0;
	logic awready, wready, bvalid, arready, rvalid, tick_enable;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [IRETC_NUM_IRQ-1:0] irq_enable_set;
	logic osc = 1'b0;
	int err_count = 0, checked = 0, ticks = 0;
	logic [1:0] resp;
	logic [31:0] word;
	// ----------------------------------------
	// clock and device
	// ----------------------------------------
	always #4 aclk = ~aclk;
	iretc_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .osc_input_pin(osc),
		.irq_enable_set(irq_enable_set), .tick_enable(tick_enable));
	// tick pulses are one cycle wide, so count them at every edge
	always @(posedge aclk) begin
		if (tick_enable === 1'b1) ticks <= ticks + 1;
	end
	// ----------------------------------------
	// report and compare
	// ----------------------------------------
	task automatic test_done;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : test_done
	task automatic chk_val(input string what, input logic [49:0] exp, input logic [49:0] got);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_val
	task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_resp
	task automatic hang;
		err_count++;
		$display("wrong value handshake expected answer seen none");
		test_done();
	endtask : hang
	// ----------------------------------------
	// bus cycles
	// ----------------------------------------
	// address and data offered together, each dropped on its own taking edge
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		bit aw_ok, w_ok, b_ok;
		int i;
		aw_ok = 0; w_ok = 0; b_ok = 0;
		awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		for (i = 0; i < 100 && !b_ok; i++) begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1) begin awvalid <= 1'b0; aw_ok = 1; end
			if (wvalid && wready === 1'b1) begin wvalid <= 1'b0; w_ok = 1; end
			if (bready && bvalid === 1'b1) begin r = bresp; bready <= 1'b0; b_ok = 1; end
		end
		if (!(aw_ok && w_ok && b_ok)) hang();
		// one idle edge, so a following call never lowers and raises bready in one step
		@(posedge aclk);
	endtask : axi_write
	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		bit ar_ok, r_ok;
		int i;
		ar_ok = 0; r_ok = 0;
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		for (i = 0; i < 100 && !r_ok; i++) begin
			@(posedge aclk);
			if (arvalid && arready === 1'b1) begin arvalid <= 1'b0; ar_ok = 1; end
			if (rready && rvalid === 1'b1) begin d = rdata; r = rresp; rready <= 1'b0; r_ok = 1; end
		end
		if (!(ar_ok && r_ok)) hang();
		// one idle edge, so a following call never lowers and raises rready in one step
		@(posedge aclk);
	endtask : axi_read
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	// 8 MHz / 32 gives 250 kHz, so 10 ms is 2500 counts
	task automatic test_calib;
		logic [31:0] exp;
		// reference clock present, and 0x9C4 is exactly 10 ms, so both flags read 0
		exp = {1'b0, 1'b0, 6'h00, 24'h0009C4};
		axi_read(IRETC_OFF_CALIB, word, resp);
		chk_val("calib", exp, word);
		chk_resp("calib rresp", IRETC_RESP_OKAY, resp);
		axi_write(IRETC_OFF_CALIB, 32'hFFFFFFFF, 4'hF, resp);
		chk_resp("calib bresp", IRETC_RESP_SLVERR, resp);
		axi_read(IRETC_OFF_CALIB, word, resp);
		chk_val("calib after write", exp, word);
		$display("test calib done");
	endtask : test_calib
	// 64 oscillator rising edges must give exactly two pulses
	task automatic test_tick;
		int i;
		int first;
		// the counting process alone writes ticks, so measure from a snapshot
		first = ticks;
		for (i = 0; i < 64; i++) begin
			@(posedge aclk) osc <= 1'b1;
			repeat (2) @(posedge aclk);
			osc <= 1'b0;
			@(posedge aclk);
		end
		repeat (6) @(posedge aclk);
		chk_val("tick count", 50'd2, ticks - first);
		$display("test tick done");
	endtask : test_tick
	task automatic test_enable;
		axi_read(IRETC_OFF_ENA_LOW, word, resp);
		chk_val("low at reset", 50'h0, word);
		axi_write(IRETC_OFF_ENA_LOW, 32'h80000001, 4'hF, resp);
		chk_resp("low bresp", IRETC_RESP_OKAY, resp);
		axi_write(IRETC_OFF_ENA_LOW, 32'h00000100, 4'h0, resp);
		axi_write(IRETC_OFF_ENA_LOW, 32'h00000000, 4'hF, resp);
		axi_write(IRETC_OFF_ENA_LOW, 32'h00010000, 4'h4, resp);
		axi_read(IRETC_OFF_ENA_LOW, word, resp);
		chk_val("low read", 50'h80010001, word);
		chk_val("low lines", 50'h80010001, irq_enable_set);
		axi_write(IRETC_OFF_ENA_HIGH, 32'hFFFFFFFF, 4'hF, resp);
		chk_resp("high bresp", IRETC_RESP_OKAY, resp);
		axi_read(IRETC_OFF_ENA_HIGH, word, resp);
		chk_val("high read", 50'h3FFFF, word);
		chk_val("all lines", {18'h3FFFF, 32'h80010001}, irq_enable_set);
		$display("test enable done");
	endtask : test_enable
	task automatic test_unmapped;
		axi_write(8'h20, 32'hFFFFFFFF, 4'hF, resp);
		chk_resp("unmapped bresp", IRETC_RESP_SLVERR, resp);
		axi_read(8'h20, word, resp);
		chk_resp("unmapped rresp", IRETC_RESP_SLVERR, resp);
		chk_val("unmapped rdata", 50'h0, word);
		chk_val("lines kept", {18'h3FFFF, 32'h80010001}, irq_enable_set);
		// oscillator is idle here, so the status word shows no tick
		axi_read(IRETC_OFF_STATUS, word, resp);
		chk_resp("status rresp", IRETC_RESP_OKAY, resp);
		chk_val("status idle", 50'h0, word);
		$display("test unmapped done");
	endtask : test_unmapped
	// a second reset in mid-run must clear every enable
	task automatic test_rereset;
		@(posedge aclk) aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk_val("lines after reset", 50'h0, irq_enable_set);
		axi_read(IRETC_OFF_ENA_HIGH, word, resp);
		chk_val("high after reset", 50'h0, word);
		$display("test rereset done");
	endtask : test_rereset
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		test_calib();
		test_tick();
		test_enable();
		test_unmapped();
		test_rereset();
		test_done();
	end
endmodule : iretc_top_test
